// [logic/scan_stepper_drive_control.sv]
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// Contract
// RL1: Each step pulse advances the carriage motor by one step.
// RL2: Controller keeps step pulses at or below 9000 per second.
// RL3: Stepping circuit starts working at the first step pulse.
// RL4: Direction high turns clockwise, low counterclockwise.
// RL5: Direction stable from 7 us before first pulse until after last.
// RL6: Enable high energises windings; enable low removes all excitation.
// RL7: Mode select not changed within 7 us after the first pulse.
// RL8: Reset low for 10 us or more initialises the whole driver.
// RL9: Driver resets itself automatically at power-up.
// RL10: Controller homes carriage using the home position sensor.
// RL11: Feeder scans hold carriage at shading then scanning position.
// RL12: Controller steps only with reset released and excitation on.
module scan_stepper_drive_control #(
   parameter logic [stepper_pkg::CNT_W-1:0] MIN_STEP_CYC =
      stepper_pkg::MIN_STEP_CNT
) (
   // Clock, reset, clock enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic [stepper_pkg::PADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Driver pins from the controller and the home position sensor
   input wire logic step_pulse_in,
   input wire logic rotation_direction,
   input wire logic excitation_enable,
   input wire logic excitation_mode_select,
   input wire logic driver_reset_n,
   input wire logic home_position_sensor,
   // Winding drive {b_n, a_n, b, a}
   output logic [stepper_pkg::COIL_W-1:0] carriage_motor
);
   import stepper_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   seq_if sq ();
   logic [PIN_N-1:0] pins;
   logic step_d_reg;
   logic dir_d_reg;
   logic mode_d_reg;
   drive_state_t state_reg;
   drive_state_t state_next;
   logic [CNT_W-1:0] rst_cnt_reg;
   logic [CNT_W-1:0] init_cnt_reg;
   logic [CNT_W-1:0] dir_age_reg;
   logic [CNT_W-1:0] mode_age_reg;
   logic [CNT_W-1:0] gap_reg;
   logic [FLAG_W-1:0] flags_reg;
   logic [FLAG_W-1:0] flags_next;
   logic [FLAG_W-1:0] flag_set;
   logic [FLAG_W-1:0] flag_clr;
   logic [POS_W-1:0] position_reg;
   logic ctrl_off_reg;
   logic soft_init_reg;
   logic step_rise;
   logic dir_chg;
   logic mode_chg;
   logic rst_long;
   logic reset_req;
   logic init_done;
   logic setup;
   logic access;
   logic wr;
   logic sel_ctrl;
   logic sel_status;
   logic sel_flags;
   logic sel_pos;
   logic mapped;
   logic [31:0] rdata;
   logic [31:0] status_word;

   if (MIN_STEP_CYC == '0) begin : g_chk
      $error("MIN_STEP_CYC must be at least one cycle");
   end

   // ---------------------------------------------------------------
   // Pin synchronisers and sequencer
   // ---------------------------------------------------------------
   pin_sync #(
      .W(PIN_N)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .d({home_position_sensor, driver_reset_n, excitation_mode_select,
          excitation_enable, rotation_direction, step_pulse_in}),
      .q(pins)
   );

   phase_sequencer u_seq (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .sq(sq.seq)
   );

   // ---------------------------------------------------------------
   // Pin events
   // ---------------------------------------------------------------
   // Edges on the synchronised pins
   assign step_rise = pins[PIN_STEP] && !step_d_reg;
   assign dir_chg = pins[PIN_DIR] != dir_d_reg;
   assign mode_chg = pins[PIN_MODE] != mode_d_reg;
   // RL8: long reset low
   assign rst_long = rst_cnt_reg >= RESET_MIN_CNT;
   assign reset_req = rst_long || soft_init_reg;
   assign init_done = (init_cnt_reg >= RESET_MIN_CNT) && !reset_req;

   // Previous pin levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_d_reg <= 1'b0;
         dir_d_reg <= 1'b0;
         mode_d_reg <= 1'b0;
      end else if (ce) begin
         step_d_reg <= pins[PIN_STEP];
         dir_d_reg <= pins[PIN_DIR];
         mode_d_reg <= pins[PIN_MODE];
      end
   end

   // ---------------------------------------------------------------
   // Drive state machine
   // ---------------------------------------------------------------
   // RL3: first pulse starts stepping
   always_comb begin
      case (state_reg)
         ST_INIT: state_next = init_done ? ST_IDLE : ST_INIT;
         ST_IDLE: begin
            if (reset_req) begin
               state_next = ST_INIT;
            end else if (step_rise) begin
               state_next = ST_RUN;
            end else begin
               state_next = ST_IDLE;
            end
         end
         ST_RUN: state_next = reset_req ? ST_INIT : ST_RUN;
         default: state_next = ST_INIT;
      endcase
   end

   // RL9: power-up starts in init
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_INIT;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // RL8: reset low time, init time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_cnt_reg <= '0;
         init_cnt_reg <= '0;
      end else if (ce) begin
         if (pins[PIN_RST_N]) begin
            rst_cnt_reg <= '0;
         end else if (!rst_long) begin
            rst_cnt_reg <= CNT_W'(rst_cnt_reg + 1'b1);
         end
         if (state_reg != ST_INIT || reset_req) begin
            init_cnt_reg <= '0;
         end else if (!init_done) begin
            init_cnt_reg <= CNT_W'(init_cnt_reg + 1'b1);
         end
      end
   end

   // RL1: one step per pulse edge
   assign sq.step = step_rise && (state_reg != ST_INIT);
   // RL4: direction level
   assign sq.dir = pins[PIN_DIR];
   assign sq.half = pins[PIN_MODE];
   // RL6: excitation gate
   assign sq.energise = (state_reg == ST_RUN) && pins[PIN_EN]
                        && !ctrl_off_reg;
   assign sq.init = state_reg == ST_INIT;
   assign carriage_motor = sq.coils;

   // ---------------------------------------------------------------
   // Controller timing monitors
   // ---------------------------------------------------------------
   // RL5: direction setup and hold
   assign flag_set[FLAG_DIR_BIT] =
      (sq.step && dir_age_reg < DIR_SETUP_CNT)
      || (dir_chg && pins[PIN_STEP]);
   // RL7: mode hold after first pulse
   assign flag_set[FLAG_MODE_BIT] = mode_chg && (state_reg == ST_RUN)
                                    && mode_age_reg < MODE_HOLD_CNT;
   // RL2: step rate limit
   assign flag_set[FLAG_SPEED_BIT] = sq.step && (state_reg == ST_RUN)
                                     && gap_reg < MIN_STEP_CYC;
   // Set wins over write-one-to-clear
   assign flags_next = (flags_reg & ~flag_clr) | flag_set;

   // Ages of last direction change, first pulse and last pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_age_reg <= '0;
         mode_age_reg <= '0;
         gap_reg <= '0;
         flags_reg <= '0;
      end else if (ce) begin
         flags_reg <= flags_next;
         if (dir_chg) begin
            dir_age_reg <= '0;
         end else if (dir_age_reg < DIR_SETUP_CNT) begin
            dir_age_reg <= CNT_W'(dir_age_reg + 1'b1);
         end
         if (state_reg != ST_RUN) begin
            mode_age_reg <= '0;
         end else if (mode_age_reg < MODE_HOLD_CNT) begin
            mode_age_reg <= CNT_W'(mode_age_reg + 1'b1);
         end
         if (sq.step) begin
            gap_reg <= '0;
         end else if (gap_reg < MIN_STEP_CYC) begin
            gap_reg <= CNT_W'(gap_reg + 1'b1);
         end
      end
   end

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   // Address decode and phases
   assign setup = psel && !penable;
   assign access = psel && penable && pready;
   assign sel_ctrl = paddr == ADDR_CTRL;
   assign sel_status = paddr == ADDR_STATUS;
   assign sel_flags = paddr == ADDR_FLAGS;
   assign sel_pos = paddr == ADDR_POSITION;
   assign mapped = sel_ctrl || sel_status || sel_flags || sel_pos;
   assign wr = access && pwrite && mapped;
   assign flag_clr = (wr && sel_flags) ? pwdata[FLAG_W-1:0] : '0;

   // Status word from live state
   always_comb begin
      status_word = '0;
      status_word[ST_RUN_BIT] = state_reg == ST_RUN;
      status_word[ST_INIT_BIT] = state_reg == ST_INIT;
      status_word[ST_EN_BIT] = sq.energise;
      status_word[ST_HOME_BIT] = pins[PIN_HOME];
      status_word[ST_PHASE_LSB +: PHASE_W] = sq.phase;
      status_word[ST_COIL_LSB +: COIL_W] = sq.coils;
   end

   // Read data select
   assign rdata = sel_ctrl ? {30'h0, ctrl_off_reg, 1'b0}
                : sel_status ? status_word
                : sel_flags ? {{(32 - FLAG_W){1'b0}}, flags_reg}
                : sel_pos ? {16'h0, position_reg}
                : 32'h0;

   // Answer registered from the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else if (ce) begin
         pready <= setup;
         pslverr <= setup && !mapped;
         prdata <= (setup && !pwrite) ? rdata : '0;
      end
   end

   // Control register and soft init pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_off_reg <= CTRL_OFF_RST;
         soft_init_reg <= 1'b0;
      end else if (ce) begin
         soft_init_reg <= wr && sel_ctrl && pwdata[CTRL_INIT_BIT];
         if (wr && sel_ctrl) begin
            ctrl_off_reg <= pwdata[CTRL_OFF_BIT];
         end
      end
   end

   // Step position counter; a step wins over a write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         position_reg <= '0;
      end else if (ce) begin
         if (sq.init) begin
            position_reg <= '0;
         end else if (sq.step) begin
            position_reg <= POS_W'(position_reg
                            + (sq.dir ? 16'h0001 : 16'hffff));
         end else if (wr && sel_pos) begin
            position_reg <= pwdata[POS_W-1:0];
         end
      end
   end

endmodule : scan_stepper_drive_control

// [inc/stepper_pkg.sv]
package stepper_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_NS = 8;
   localparam int DIR_SETUP_NS = 7000;
   localparam int MODE_HOLD_NS = 7000;
   localparam int RESET_MIN_NS = 10000;
   localparam int MAX_PPS = 9000;
   localparam int CNT_W = 16;
   // Least times round up to whole cycles
   localparam int DIR_SETUP_CYC = (DIR_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int MODE_HOLD_CYC = (MODE_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int MIN_STEP_CYC =
      (1000000000 + MAX_PPS * CLK_NS - 1) / (MAX_PPS * CLK_NS);
   localparam logic [CNT_W-1:0] DIR_SETUP_CNT = CNT_W'(DIR_SETUP_CYC);
   localparam logic [CNT_W-1:0] MODE_HOLD_CNT = CNT_W'(MODE_HOLD_CYC);
   localparam logic [CNT_W-1:0] RESET_MIN_CNT = CNT_W'(RESET_MIN_CYC);
   localparam logic [CNT_W-1:0] MIN_STEP_CNT = CNT_W'(MIN_STEP_CYC);

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int PADDR_W = 8;
   localparam logic [PADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [PADDR_W-1:0] ADDR_STATUS = 8'h04;
   localparam logic [PADDR_W-1:0] ADDR_FLAGS = 8'h08;
   localparam logic [PADDR_W-1:0] ADDR_POSITION = 8'h0c;
   localparam int CTRL_INIT_BIT = 0;
   localparam int CTRL_OFF_BIT = 1;
   localparam logic CTRL_OFF_RST = 1'b0;
   localparam int ST_RUN_BIT = 0;
   localparam int ST_INIT_BIT = 1;
   localparam int ST_EN_BIT = 2;
   localparam int ST_HOME_BIT = 3;
   localparam int ST_PHASE_LSB = 4;
   localparam int ST_COIL_LSB = 8;
   localparam int FLAG_W = 3;
   localparam int FLAG_DIR_BIT = 0;
   localparam int FLAG_MODE_BIT = 1;
   localparam int FLAG_SPEED_BIT = 2;
   localparam int POS_W = 16;
   localparam int PHASE_W = 3;
   localparam int COIL_W = 4;
   localparam logic [PHASE_W-1:0] PHASE_RST = 3'h0;

   // ---------------------------------------------------------------
   // Pin vector layout and states
   // ---------------------------------------------------------------
   localparam int PIN_STEP = 0;
   localparam int PIN_DIR = 1;
   localparam int PIN_EN = 2;
   localparam int PIN_MODE = 3;
   localparam int PIN_RST_N = 4;
   localparam int PIN_HOME = 5;
   localparam int PIN_N = 6;

   typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_RUN} drive_state_t;

endpackage : stepper_pkg

// [inc/seq_if.sv]
`timescale 1ns/100ps
interface seq_if;
   import stepper_pkg::*;
   logic step;
   logic dir;
   logic half;
   logic energise;
   logic init;
   logic [PHASE_W-1:0] phase;
   logic [COIL_W-1:0] coils;
   modport ctl(output step, dir, half, energise, init, input phase, coils);
   modport seq(input step, dir, half, energise, init, output phase, coils);
endinterface : seq_if

// [logic/pin_sync.sv]
`timescale 1ns/100ps
module pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Pins in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] s1_reg;

   if (W < 1) begin : g_chk
      $error("pin_sync needs W of at least 1");
   end

   // Two flops per pin, first one read only by the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= '0;
         q <= '0;
      end else if (ce) begin
         s1_reg <= d;
         q <= s1_reg;
      end
   end

endmodule : pin_sync

// [logic/phase_sequencer.sv]
`timescale 1ns/100ps
module phase_sequencer (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Control side
   seq_if.seq sq
);
   import stepper_pkg::*;

   logic [PHASE_W-1:0] delta;
   logic [PHASE_W-1:0] phase_next;
   logic [PHASE_W-1:0] phase_show;

   // Coil pattern per half-step position: {b_n, a_n, b, a}
   function automatic logic [COIL_W-1:0] coil_map(
      input logic [PHASE_W-1:0] p);
      case (p)
         3'h0: coil_map = 4'h1;
         3'h1: coil_map = 4'h3;
         3'h2: coil_map = 4'h2;
         3'h3: coil_map = 4'h6;
         3'h4: coil_map = 4'h4;
         3'h5: coil_map = 4'hc;
         3'h6: coil_map = 4'h8;
         default: coil_map = 4'h9;
      endcase
   endfunction : coil_map

   // Half mode moves one position; full mode lands on two-coil positions
   assign delta = (sq.half || !sq.phase[0]) ? 3'h1 : 3'h2;
   assign phase_next = sq.dir ? PHASE_W'(sq.phase + delta)
                              : PHASE_W'(sq.phase - delta);
   assign phase_show = sq.step ? phase_next : sq.phase;

   // Phase position and registered coil drive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sq.phase <= PHASE_RST;
         sq.coils <= '0;
      end else if (ce) begin
         if (sq.init) begin
            sq.phase <= PHASE_RST;
            sq.coils <= '0;
         end else begin
            if (sq.step) begin
               sq.phase <= phase_next;
            end
            sq.coils <= sq.energise ? coil_map(phase_show) : '0;
         end
      end
   end

endmodule : phase_sequencer

// [verif/step_drive_chk.sv]
`timescale 1ns/100ps
module step_drive_chk #(
   parameter logic [stepper_pkg::CNT_W-1:0] MIN_STEP_CYC =
      stepper_pkg::MIN_STEP_CNT
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic [stepper_pkg::PADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins
   input wire logic step_pulse_in,
   input wire logic excitation_enable,
   input wire logic driver_reset_n,
   input wire logic [stepper_pkg::COIL_W-1:0] carriage_motor
);
   import stepper_pkg::*;
   logic [10:0] quiet;
   logic [10:0] rlow;
   logic [3:0] age;
   logic step_q;
   logic off_q;
   logic moved_q;
   // Decodes of the watched ports
   wire rise = step_pulse_in & ~step_q;
   wire ready = quiet > 11'h514;
   wire mapped = paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_FLAGS,
      ADDR_POSITION};
   wire ctrl_wr = psel & penable & pready & pwrite & (paddr == ADDR_CTRL);

   // Reset age, step age and coil-off shadow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet <= 11'h0;
         rlow <= 11'h0;
         age <= 4'hf;
         step_q <= 1'b0;
         off_q <= CTRL_OFF_RST;
         moved_q <= 1'b0;
      end else begin
         rlow <= driver_reset_n ? 11'h0 : rlow + {10'h0, rlow != 11'h7ff};
         // Quiet restarts once the design has surely entered init
         quiet <= (rlow >= 11'h4ec) ? 11'h0 :
            quiet + {10'h0, quiet != 11'h7ff};
         age <= rise ? 4'h0 : age + {3'h0, age != 4'hf};
         step_q <= step_pulse_in;
         off_q <= ctrl_wr ? pwdata[CTRL_OFF_BIT] : off_q;
         moved_q <= (rise && quiet > 11'h4b0) || (moved_q && quiet != 11'h0);
      end
   end

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence

   AST_APB_ANSWER:
   assert property (s_setup |=> s_done)
      else $error("APB access not answered in first access cycle");
   AST_APB_UNMAPPED:
   assert property (s_setup ##0 !mapped |=> pslverr && prdata == 32'h0)
      else $error("unmapped access without error");
   AST_READY_PULSE:
   assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_POWERUP_OFF:
   assert property (quiet < 11'h4e2 |-> carriage_motor == 4'h0)
      else $error("coils driven during init");
   AST_LONG_RESET_OFF:
   assert property (rlow > 11'h4ec |-> carriage_motor == 4'h0)
      else $error("coils driven while driver reset held");
   AST_ENABLE_OFF:
   assert property (!excitation_enable [*5] |-> carriage_motor == 4'h0)
      else $error("coils driven with enable low");
   AST_STEP_MOVES:
   assert property (rise && ready && excitation_enable && !off_q |->
      ##[2:6] $changed(carriage_motor))
      else $error("step did not move coils");
   AST_NO_SPURIOUS:
   assert property ($changed(carriage_motor) && carriage_motor != 4'h0 &&
      $past(carriage_motor) != 4'h0 |-> age inside {[4'h1:4'h8]})
      else $error("coils moved without a step");
   AST_IDLE_OFF:
   assert property (!moved_q |-> carriage_motor == 4'h0)
      else $error("coils driven before first step");
endmodule : step_drive_chk

bind scan_stepper_drive_control step_drive_chk #(
   .MIN_STEP_CYC(MIN_STEP_CYC)
) u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
   .prdata, .pready, .pslverr, .step_pulse_in, .excitation_enable,
   .driver_reset_n, .carriage_motor);

// [verif/step_ctl_model.sv]
`timescale 1ns/100ps
module step_ctl_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Command from the bench
   input wire logic go,
   input wire logic dir_in,
   input wire logic [7:0] n_steps,
   input wire logic [15:0] gap,
   // Pins toward the driver, busy back to the bench
   output logic step_pulse_in,
   output logic rotation_direction,
   output logic busy
);
   import stepper_pkg::*;
   // Idle levels
   initial begin
      step_pulse_in = 1'b0;
      rotation_direction = 1'b0;
      busy = 1'b0;
   end
   // One run of pulses per command
   always begin
      @(posedge pclk);
      if (go && presetn) begin
         busy <= 1'b1;
         rotation_direction <= dir_in;
         repeat (DIR_SETUP_CYC + 4) @(posedge pclk);
         for (int i = 0; i < n_steps; i++) begin
            step_pulse_in <= 1'b1;
            repeat (gap / 2) @(posedge pclk);
            step_pulse_in <= 1'b0;
            repeat (gap - gap / 2) @(posedge pclk);
         end
         busy <= 1'b0;
      end
   end
endmodule : step_ctl_model

// [verif/tb.sv]
`timescale 1ns/100ps
module tb;
   import stepper_pkg::*;
   localparam logic [CNT_W-1:0] MIN_GAP = 16'h0014;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [PADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic step_pulse_in, rotation_direction, excitation_enable;
   logic excitation_mode_select, driver_reset_n, home_position_sensor;
   logic [COIL_W-1:0] carriage_motor;
   logic go, dir_in, busy, ce;
   logic [7:0] n_steps;
   logic [15:0] gap, pos_e;
   logic [PHASE_W-1:0] ph_e;
   int fails, total_checks, r;
   logic [COIL_W-1:0] coil_tab [8] = '{4'h1, 4'h3, 4'h2, 4'h6, 4'h4,
      4'hc, 4'h8, 4'h9};

   scan_stepper_drive_control #(.MIN_STEP_CYC(MIN_GAP)) dut (.pclk,
      .presetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .step_pulse_in, .rotation_direction,
      .excitation_enable, .excitation_mode_select, .driver_reset_n,
      .home_position_sensor, .carriage_motor);
   step_ctl_model partner (.pclk, .presetn, .go, .dir_in, .n_steps, .gap,
      .step_pulse_in, .rotation_direction, .busy);

   // Clock
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic apb(input logic [PADDR_W-1:0] a, input logic w,
      input logic [31:0] wd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         fails++;
         wrap_up();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic [PHASE_W-1:0] next_ph(logic [PHASE_W-1:0] p,
      logic cw, logic half);
      logic [PHASE_W-1:0] d;
      d = (half || !p[0]) ? 3'h1 : 3'h2;
      return cw ? p + d : p - d;
   endfunction : next_ph

   task automatic move(input logic d, input logic [7:0] n,
      input logic [15:0] g);
      int i;
      @(posedge pclk);
      go <= 1'b1;
      dir_in <= d;
      n_steps <= n;
      gap <= g;
      @(posedge pclk);
      go <= 1'b0;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (busy !== 1'b0 && i < 3000);
      if (busy !== 1'b0) begin
         fails++;
         wrap_up();
      end
      repeat (8) @(posedge pclk);
      for (i = 0; i < n; i++) begin
         ph_e = next_ph(ph_e, d, excitation_mode_select);
         pos_e = d ? pos_e + 16'h1 : pos_e - 16'h1;
      end
   endtask : move

   task automatic check_state(input logic [COIL_W-1:0] coil_exp);
      apb(ADDR_STATUS, 1'b0, 32'h0);
      check("phase", rd[ST_PHASE_LSB +: PHASE_W], ph_e);
      apb(ADDR_POSITION, 1'b0, 32'h0);
      check("position", rd[POS_W-1:0], pos_e);
      check("coils", carriage_motor, coil_exp);
   endtask : check_state

   task automatic wait_init();
      int i;
      i = 0;
      do begin
         apb(ADDR_STATUS, 1'b0, 32'h0);
         i++;
      end while (rd[ST_INIT_BIT] !== 1'b0 && i < 800);
      if (rd[ST_INIT_BIT] !== 1'b0) begin
         fails++;
         wrap_up();
      end
   endtask : wait_init

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, go, dir_in, err} = 7'h0;
      {paddr, pwdata, n_steps, gap} = '0;
      {excitation_mode_select, home_position_sensor} = 2'h0;
      {excitation_enable, driver_reset_n, ce} = 3'h7;
      fails = 0;
      total_checks = 0;
      r = $urandom(50);
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(ADDR_STATUS, 1'b0, 32'h0);
      check("init flag", rd[ST_INIT_BIT], 1'b1);
      check("init coils", carriage_motor, 4'h0);
      apb(8'h10, 1'b0, 32'h0);
      check("unmapped error", err, 1'b1);
      wait_init();
      ph_e = PHASE_RST;
      pos_e = 16'($urandom);
      apb(ADDR_POSITION, 1'b1, {16'h0, pos_e});
      check("idle coils", carriage_motor, 4'h0);
      $display("test power-up done");
      for (int k = 0; k < 6; k++) begin
         r = $urandom;
         excitation_mode_select <= r[1];
         move(r[0], 8'(1 + r[4:2]), 16'(24 + r[9:5]));
         check_state(coil_tab[ph_e]);
         repeat (20) @(posedge pclk);
         check("held coils", carriage_motor, coil_tab[ph_e]);
      end
      home_position_sensor <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(ADDR_STATUS, 1'b0, 32'h0);
      check("home", rd[ST_HOME_BIT], 1'b1);
      $display("test random steps done");
      excitation_enable <= 1'b0;
      move(1'b1, 8'h3, 16'h001e);
      check_state(4'h0);
      excitation_enable <= 1'b1;
      repeat (6) @(posedge pclk);
      check("enable back", carriage_motor, coil_tab[ph_e]);
      // Clock enable low freezes the coils through a short enable dip
      ce <= 1'b0;
      excitation_enable <= 1'b0;
      repeat (3) @(posedge pclk);
      excitation_enable <= 1'b1;
      repeat (3) @(posedge pclk);
      check("frozen coils", carriage_motor, coil_tab[ph_e]);
      ce <= 1'b1;
      apb(ADDR_CTRL, 1'b1, 32'h2);
      apb(ADDR_CTRL, 1'b0, 32'h0);
      check("ctrl", rd, 32'h2);
      repeat (6) @(posedge pclk);
      check("forced off", carriage_motor, 4'h0);
      apb(ADDR_CTRL, 1'b1, 32'h0);
      $display("test excitation done");
      move(1'b0, 8'h4, 16'h000a);
      apb(ADDR_FLAGS, 1'b0, 32'h0);
      check("speed flag", rd[FLAG_SPEED_BIT], 1'b1);
      apb(ADDR_FLAGS, 1'b1, 32'h1 << FLAG_SPEED_BIT);
      apb(ADDR_FLAGS, 1'b0, 32'h0);
      check("speed flag clear", rd[FLAG_SPEED_BIT], 1'b0);
      $display("test rate monitor done");
      driver_reset_n <= 1'b0;
      repeat (1300) @(posedge pclk);
      check("reset coils", carriage_motor, 4'h0);
      driver_reset_n <= 1'b1;
      wait_init();
      {ph_e, pos_e} = '0;
      check_state(4'h0);
      excitation_mode_select <= 1'b0;
      move(1'b1, 8'h1, 16'h001e);
      check_state(coil_tab[1]);
      $display("test driver reset done");
      wrap_up();
   end
endmodule : tb
